/* core/adcseq_top.sv */
// Converter sequencing, prescaler, result and APB register logic
`timescale 1ns/1ps
`include "adcseq_cfg.svh"
module adcseq_top
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [6:0]  trigger_in,
   input  wire logic [9:0]  conv_data,
   input  wire logic        irq_ack,
   output logic             converter_power,
   output logic             sample_hold,
   output logic      [3:0]  analog_channel,
   output logic      [1:0]  analog_reference,
   output logic             conversion_busy,
   output logic             complete_flag
);
   adcseq_pkg::adcseq_state_t state_reg;
   adcseq_pkg::adcseq_kind_t  kind_reg;
   logic [7:0] ctrl_a_reg;
   logic [2:0] ctrl_b_reg;
   logic [7:0] insel_reg;
   logic       power_off_reg;
   logic       start_reg;
   logic       flag_reg;
   logic       first_reg;
   logic       lock_reg;
   logic       trig_prev_reg;
   logic [1:0] sync_cnt_reg;
   logic [5:0] half_reg;
   logic [6:0] presc_reg;
   logic [9:0] result_reg;
   logic [5:0] cfg_reg;
   logic       sample_reg;
   logic       enable;
   logic       wr_acc;
   logic       rd_acc;
   logic       setup;
   logic [7:0] ratio;
   logic       rise_tick;
   logic       fall_tick;
   logic       half_tick;
   logic       trig_level;
   logic       trig_edge;
   logic       sw_start;
   logic [5:0] sample_pt;
   logic [5:0] end_pt;
   logic       done;
   logic       mapped;
   logic [7:0] res_low;
   logic [7:0] res_high;
   logic [7:0] rd_mux;

   assign setup   = psel & ~penable;
   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign mapped  = (paddr == `ADCSEQ_OFF_CTRL_A) ||
                    (paddr == `ADCSEQ_OFF_CTRL_B) ||
                    (paddr == `ADCSEQ_OFF_INSEL) ||
                    (paddr == `ADCSEQ_OFF_RES_LOW) ||
                    (paddr == `ADCSEQ_OFF_RES_HIGH) ||
                    (paddr == `ADCSEQ_OFF_POWER);
   assign pslverr = psel & penable & ~mapped;

   // Converter runs only when enabled and not powered down
   assign enable = ctrl_a_reg[`ADCSEQ_BIT_ENABLE] & ~power_off_reg;
   assign converter_power = enable;

   // Power-of-two ratio from 2 to 128
   assign ratio = (ctrl_a_reg[2:0] == 3'h7) ? 8'h80 :
                  8'(8'h02 << ctrl_a_reg[2:0]);
   assign rise_tick = (presc_reg >= 7'(ratio - 8'h01));
   assign fall_tick = (presc_reg == 7'((ratio >> 1) - 8'h01));
   assign half_tick = rise_tick | fall_tick;

   // Trigger selection, code zero is the own completion flag
   assign trig_level = (ctrl_b_reg == `ADCSEQ_TRIG_SELF) ? flag_reg :
                       trigger_in[3'(ctrl_b_reg - 3'h1)];
   assign trig_edge = trig_level & ~trig_prev_reg &
                      (ctrl_b_reg != `ADCSEQ_TRIG_SELF);
   assign sw_start = wr_acc & (paddr == `ADCSEQ_OFF_CTRL_A) &
                     pwdata[`ADCSEQ_BIT_START] & enable;

   always_comb
   begin
      case (kind_reg)
         adcseq_pkg::ADCSEQ_K_FIRST:
         begin
            sample_pt = `ADCSEQ_HALF_SAMPLE_F;
            end_pt    = `ADCSEQ_HALF_END_F;
         end
         adcseq_pkg::ADCSEQ_K_AUTO:
         begin
            sample_pt = `ADCSEQ_HALF_SAMPLE_A;
            end_pt    = `ADCSEQ_HALF_END_A;
         end
         default:
         begin
            sample_pt = `ADCSEQ_HALF_SAMPLE_N;
            end_pt    = `ADCSEQ_HALF_END_N;
         end
      endcase
   end

   assign done = (state_reg == adcseq_pkg::ADCSEQ_CONV) & half_tick &
                 (half_reg == 6'(end_pt - 6'h01));
   assign conversion_busy = start_reg;
   assign complete_flag   = flag_reg;
   assign sample_hold     = sample_reg;

   // Prescaler
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         presc_reg <= 7'h00;
      else if (!enable)
         presc_reg <= 7'h00;
      else if (state_reg == adcseq_pkg::ADCSEQ_IDLE &&
               ctrl_a_reg[`ADCSEQ_BIT_AUTO] && trig_edge)
         presc_reg <= 7'h00;
      else if (rise_tick)
         presc_reg <= 7'h00;
      else
         presc_reg <= presc_reg + 7'h01;
   end

   // Sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg    <= adcseq_pkg::ADCSEQ_IDLE;
         kind_reg     <= adcseq_pkg::ADCSEQ_K_NORMAL;
         half_reg     <= 6'h00;
         sync_cnt_reg <= 2'h0;
      end
      else if (!enable)
         state_reg <= adcseq_pkg::ADCSEQ_IDLE;
      else
      begin
         case (state_reg)
            adcseq_pkg::ADCSEQ_IDLE:
            begin
               if (sw_start)
                  state_reg <= adcseq_pkg::ADCSEQ_WAIT;
               else if (ctrl_a_reg[`ADCSEQ_BIT_AUTO] && trig_edge)
               begin
                  state_reg    <= adcseq_pkg::ADCSEQ_SYNC;
                  sync_cnt_reg <= 2'h1;
               end
            end
            adcseq_pkg::ADCSEQ_WAIT:
            begin
               if (rise_tick)
               begin
                  state_reg <= adcseq_pkg::ADCSEQ_CONV;
                  half_reg  <= 6'h00;
                  kind_reg  <= first_reg ? adcseq_pkg::ADCSEQ_K_FIRST :
                               adcseq_pkg::ADCSEQ_K_NORMAL;
               end
            end
            adcseq_pkg::ADCSEQ_SYNC:
            begin
               if (sync_cnt_reg == `ADCSEQ_SYNC_CYCLES)
               begin
                  state_reg <= adcseq_pkg::ADCSEQ_CONV;
                  half_reg  <= 6'h00;
                  kind_reg  <= first_reg ? adcseq_pkg::ADCSEQ_K_FIRST :
                               adcseq_pkg::ADCSEQ_K_AUTO;
               end
               else
                  sync_cnt_reg <= sync_cnt_reg + 2'h1;
            end
            adcseq_pkg::ADCSEQ_CONV:
            begin
               if (done)
               begin
                  half_reg <= 6'h00;
                  kind_reg <= adcseq_pkg::ADCSEQ_K_NORMAL;
                  if (!(ctrl_a_reg[`ADCSEQ_BIT_AUTO] &&
                        ctrl_b_reg == `ADCSEQ_TRIG_SELF))
                     state_reg <= adcseq_pkg::ADCSEQ_IDLE;
                  // Free running restarts on the next half cycle
               end
               else if (half_tick)
                  half_reg <= half_reg + 6'h01;
            end
            default:
               state_reg <= adcseq_pkg::ADCSEQ_IDLE;
         endcase
      end
   end

   // First-conversion marker, armed while disabled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         first_reg <= 1'b1;
      else if (!enable)
         first_reg <= 1'b1;
      else if (state_reg == adcseq_pkg::ADCSEQ_CONV)
         first_reg <= 1'b0;
   end

   // Start bit reads one for any conversion in progress
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         start_reg <= 1'b0;
      else if (!enable)
         start_reg <= 1'b0;
      else if (sw_start || (state_reg == adcseq_pkg::ADCSEQ_IDLE &&
               ctrl_a_reg[`ADCSEQ_BIT_AUTO] && trig_edge))
         start_reg <= 1'b1;
      else if (done && !(ctrl_a_reg[`ADCSEQ_BIT_AUTO] &&
               ctrl_b_reg == `ADCSEQ_TRIG_SELF))
         start_reg <= 1'b0;
   end

   // Sample-and-hold strobe
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sample_reg <= 1'b0;
      else
         sample_reg <= (state_reg == adcseq_pkg::ADCSEQ_CONV) & half_tick &
                       (half_reg == 6'(sample_pt - 6'h01));
   end

   // Trigger edge history
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trig_prev_reg <= 1'b0;
      else
         trig_prev_reg <= trig_level;
   end

   // Completion flag, set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_reg <= 1'b0;
      else if (done)
         flag_reg <= 1'b1;
      else if (irq_ack || (wr_acc && paddr == `ADCSEQ_OFF_CTRL_A &&
               pwdata[`ADCSEQ_BIT_FLAG]))
         flag_reg <= 1'b0;
   end

   // Result capture unless locked by a low-byte read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         result_reg <= 10'h000;
      else if (done && !lock_reg)
         result_reg <= conv_data;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lock_reg <= 1'b0;
      else if (rd_acc && paddr == `ADCSEQ_OFF_RES_LOW)
         lock_reg <= 1'b1;
      else if (rd_acc && paddr == `ADCSEQ_OFF_RES_HIGH)
         lock_reg <= 1'b0;
   end

   // Selection follows writes while enabled, except during a conversion before its last two half cycles
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_reg <= 6'h00;
      else if (enable && (state_reg != adcseq_pkg::ADCSEQ_CONV ||
               half_reg >= 6'(end_pt - 6'h02)))
         cfg_reg <= {insel_reg[7:6], insel_reg[3:0]};
   end
   assign analog_reference = cfg_reg[5:4];
   assign analog_channel   = cfg_reg[3:0];

   // Software registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_a_reg    <= `ADCSEQ_CTRL_A_RST;
         ctrl_b_reg    <= `ADCSEQ_CTRL_B_RST;
         insel_reg     <= `ADCSEQ_INSEL_RST;
         power_off_reg <= `ADCSEQ_PWROFF_RST;
      end
      else if (wr_acc)
      begin
         case (paddr)
            `ADCSEQ_OFF_CTRL_A:
               ctrl_a_reg <= {pwdata[7:5], 1'b0, pwdata[3:0]};
            `ADCSEQ_OFF_CTRL_B:
               ctrl_b_reg <= pwdata[2:0];
            `ADCSEQ_OFF_INSEL:
               insel_reg <= {pwdata[7:5], 1'b0, pwdata[3:0]};
            `ADCSEQ_OFF_POWER:
               power_off_reg <= pwdata[`ADCSEQ_BIT_PWROFF];
            default:
               ctrl_b_reg <= ctrl_b_reg;
         endcase
      end
   end

   // Result justification
   assign res_high = insel_reg[`ADCSEQ_BIT_LEFT] ? result_reg[9:2] :
                     {6'h00, result_reg[9:8]};
   assign res_low  = insel_reg[`ADCSEQ_BIT_LEFT] ?
                     {result_reg[1:0], 6'h00} : result_reg[7:0];

   always_comb
   begin
      case (paddr)
         `ADCSEQ_OFF_CTRL_A:
            rd_mux = {ctrl_a_reg[7], start_reg, ctrl_a_reg[5], flag_reg,
                      ctrl_a_reg[3:0]};
         `ADCSEQ_OFF_CTRL_B:
            rd_mux = {5'h00, ctrl_b_reg};
         `ADCSEQ_OFF_INSEL:
            rd_mux = insel_reg;
         `ADCSEQ_OFF_RES_LOW:
            rd_mux = res_low;
         `ADCSEQ_OFF_RES_HIGH:
            rd_mux = res_high;
         `ADCSEQ_OFF_POWER:
            rd_mux = {7'h00, power_off_reg};
         default:
            rd_mux = 8'h00;
      endcase
   end

   // Read data registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (setup)
         prdata <= {24'h00_0000, rd_mux};
   end

   sequence s_low_read;
      rd_acc && paddr == `ADCSEQ_OFF_RES_LOW;
   endsequence
   sequence s_locked_done;
      lock_reg && done;
   endsequence

   a_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)
      s_locked_done |=> $stable(result_reg))
      else $error("result changed while locked");
   a_lock_set: assert property (@(posedge pclk) disable iff (!presetn)
      s_low_read |=> lock_reg)
      else $error("low read did not lock");
   a_flag_locked: assert property (@(posedge pclk) disable iff (!presetn)
      s_locked_done |=> flag_reg)
      else $error("flag missing on discarded result");
   a_start_clear: assert property (@(posedge pclk) disable iff (!presetn)
      done && !ctrl_a_reg[`ADCSEQ_BIT_AUTO] |=> !start_reg)
      else $error("start bit not cleared at end");
   a_busy_reads: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == adcseq_pkg::ADCSEQ_CONV |-> start_reg)
      else $error("start bit low during conversion");
   a_presc_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !enable |=> presc_reg == 7'h00)
      else $error("prescaler ran while disabled");
   a_sync_three: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_reg == adcseq_pkg::ADCSEQ_SYNC) && enable |->
      ##2 state_reg == adcseq_pkg::ADCSEQ_SYNC)
      else $error("trigger sync too short");
   a_sel_locked: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == adcseq_pkg::ADCSEQ_CONV &&
      half_reg < 6'(end_pt - 6'h02) && $past(half_reg) < half_reg |->
      $stable(cfg_reg))
      else $error("selection changed mid conversion");
   a_wait_edge: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == adcseq_pkg::ADCSEQ_WAIT && !rise_tick && enable |=>
      state_reg == adcseq_pkg::ADCSEQ_WAIT)
      else $error("start left wait without clock edge");
   a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
      done |=> flag_reg)
      else $error("completion flag not set");
endmodule

/* include/adcseq_cfg.svh */
// Offsets, field positions, reset values and timing counts
`ifndef ADCSEQ_CFG_SVH
`define ADCSEQ_CFG_SVH
`define ADCSEQ_OFF_CTRL_A     8'h00
`define ADCSEQ_OFF_CTRL_B     8'h04
`define ADCSEQ_OFF_INSEL      8'h08
`define ADCSEQ_OFF_RES_LOW    8'h0c
`define ADCSEQ_OFF_RES_HIGH   8'h10
`define ADCSEQ_OFF_POWER      8'h14
`define ADCSEQ_BIT_ENABLE     7
`define ADCSEQ_BIT_START      6
`define ADCSEQ_BIT_AUTO       5
`define ADCSEQ_BIT_FLAG       4
`define ADCSEQ_BIT_LEFT       5
`define ADCSEQ_BIT_PWROFF     0
`define ADCSEQ_CTRL_A_RST     8'h00
`define ADCSEQ_CTRL_B_RST     3'h0
`define ADCSEQ_INSEL_RST      8'h00
`define ADCSEQ_PWROFF_RST     1'b0
`define ADCSEQ_TRIG_SELF      3'h0
`define ADCSEQ_SYNC_CYCLES    2'h3
`define ADCSEQ_HALF_SAMPLE_N  6'h03
`define ADCSEQ_HALF_SAMPLE_F  6'h1b
`define ADCSEQ_HALF_SAMPLE_A  6'h04
`define ADCSEQ_HALF_END_N     6'h1a
`define ADCSEQ_HALF_END_F     6'h32
`define ADCSEQ_HALF_END_A     6'h1b
`endif

/* include/adcseq_pkg.sv */
// Types shared by the conversion sequencer
package adcseq_pkg;
   typedef enum logic [3:0] {
      ADCSEQ_IDLE = 4'b0001,
      ADCSEQ_WAIT = 4'b0010,
      ADCSEQ_SYNC = 4'b0100,
      ADCSEQ_CONV = 4'b1000
   } adcseq_state_t;
   typedef enum logic [1:0] {
      ADCSEQ_K_NORMAL = 2'h0,
      ADCSEQ_K_FIRST  = 2'h1,
      ADCSEQ_K_AUTO   = 2'h2
   } adcseq_kind_t;
endpackage

/* sim/adc_conversion_sequencer_test.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "adcseq_cfg.svh"
module adc_conversion_sequencer_test;
   localparam logic [7:0] off_a  = `ADCSEQ_OFF_CTRL_A;
   localparam logic [7:0] off_b  = `ADCSEQ_OFF_CTRL_B;
   localparam logic [7:0] off_in = `ADCSEQ_OFF_INSEL;
   localparam logic [7:0] off_lo = `ADCSEQ_OFF_RES_LOW;
   localparam logic [7:0] off_hi = `ADCSEQ_OFF_RES_HIGH;
   localparam logic [7:0] off_pw = `ADCSEQ_OFF_POWER;
   logic        pclk, presetn, psel, penable, pwrite, irq_ack;
   logic        pready, pslverr, converter_power, sample_hold;
   logic        conversion_busy, complete_flag;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [6:0]  trigger_in;
   logic [9:0]  conv_data, code_base, v;
   logic [3:0]  analog_channel;
   logic [1:0]  analog_reference;
   logic [32:0] rq_val[$], rq_mask[$];
   int          bq_lo[$], bq_hi[$];
   int          failures, compares, run, sh_cnt, s0, ch;

   adcseq_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trigger_in(trigger_in), .conv_data(conv_data), .irq_ack(irq_ack),
      .converter_power(converter_power), .sample_hold(sample_hold),
      .analog_channel(analog_channel), .analog_reference(analog_reference),
      .conversion_busy(conversion_busy), .complete_flag(complete_flag));

   adcseq_analog_model u_model (.pclk(pclk), .presetn(presetn),
      .sample_hold(sample_hold), .analog_channel(analog_channel),
      .converter_power(converter_power), .code_base(code_base),
      .conv_data(conv_data));

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task chk(input string name, input logic [32:0] seen, input logic [32:0] e);
      compares++;
      if (seen !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, e, seen);
      end
   endtask

   task end_sim;
      if (rq_val.size() != 0 || bq_lo.size() != 0)
         failures++;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task timeout(input string name);
      $display("[FAIL] %s expected done seen timeout", name);
      failures++;
      end_sim();
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [32:0] e, input logic [32:0] m);
      int n;
      @(posedge pclk);
      if (!wr)
      begin
         rq_val.push_back(e);
         rq_mask.push_back(m);
      end
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         timeout("pready");
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0, 33'h0);
   endtask

   task rdx(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e}, {33{1'b1}});
   endtask

   task wait_busy(input logic lvl, input int max);
      int n;
      n = 0;
      while (conversion_busy !== lvl && n < max)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= max)
         timeout("busy");
   endtask

   task expect_run(input int lo, input int hi);
      bq_lo.push_back(lo);
      bq_hi.push_back(hi);
   endtask

   task conv(input logic [7:0] c, input int lo, input int hi);
      expect_run(lo, hi);
      s0 = sh_cnt;
      wr(off_a, {24'h0, c});
      wait_busy(1'b1, 40);
      wait_busy(1'b0, 2000);
      chk("sample_pulses", 33'(sh_cnt - s0), 33'h1);
   endtask

   task res(input logic [9:0] r, input logic left);
      if (left)
      begin
         rdx(off_lo, {24'h0, r[1:0], 6'h00});
         rdx(off_hi, {24'h0, r[9:2]});
      end
      else
      begin
         rdx(off_lo, {24'h0, r[7:0]});
         rdx(off_hi, {22'h0, r[9:8]});
      end
   endtask

   function logic [9:0] val(input logic [3:0] c);
      return code_base + {6'h00, c};
   endfunction

   // Read data checked against the oldest noted expectation
   always @(posedge pclk)
   begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
          pwrite === 1'b0)
      begin
         if (rq_val.size() == 0)
            chk("read_unexpected", 33'h1, 33'h0);
         else
            chk("apb_read", {pslverr, prdata} & rq_mask[0],
                rq_val[0] & rq_mask[0]);
         if (rq_val.size() != 0)
         begin
            void'(rq_val.pop_front());
            void'(rq_mask.pop_front());
         end
      end
   end

   // Busy run length checked against the oldest noted window
   always @(posedge pclk)
   begin
      if (sample_hold === 1'b1)
         sh_cnt <= sh_cnt + 1;
      if (conversion_busy === 1'b1)
         run <= run + 1;
      else if (run != 0)
      begin
         if (bq_lo.size() == 0)
            chk("extra_conversion", 33'h1, 33'h0);
         else
            chk("busy_cycles", {32'h0, run >= bq_lo[0] && run <= bq_hi[0]},
                33'h1);
         if (bq_lo.size() != 0)
         begin
            void'(bq_lo.pop_front());
            void'(bq_hi.pop_front());
         end
         run <= 0;
      end
   end

   initial
   begin
      {presetn, psel, penable, pwrite, irq_ack} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      trigger_in = 7'h00;
      code_base = 10'h000;
      seed = $urandom(32'h99f5);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      code_base <= 10'($urandom);
      // Reset values, last one unmapped
      for (int i = 0; i < 7; i++)
         apb(1'b0, 8'(i * 4), 32'h0, {i == 6, 32'h0}, {33{1'b1}});
      wr(off_in, 32'hc5);
      repeat (2) @(posedge pclk);
      chk("channel_off", {29'h0, analog_channel}, 33'h0);
      chk("reference_off", {31'h0, analog_reference}, 33'h0);
      wr(off_a, 32'h80);
      repeat (2) @(posedge pclk);
      chk("channel_on", {29'h0, analog_channel}, 33'h5);
      chk("reference_on", {31'h0, analog_reference}, 33'h3);
      chk("power_on", {32'h0, converter_power}, 33'h1);
      wr(off_pw, 32'h01);
      repeat (2) @(posedge pclk);
      chk("power_off", {32'h0, converter_power}, 33'h0);
      wr(off_pw, 32'h00);
      conv(8'hc0, 50, 56);
      rdx(off_a, 32'h90);
      res(val(4'h5), 1'b0);
      wr(off_a, 32'h90);
      rdx(off_a, 32'h80);
      for (int d = 0; d < 3; d++)
         conv(8'hc0 | 8'(d), 26 << d, (28 << d) + 4);
      expect_run(26, 32);
      wr(off_a, 32'hc0);
      repeat (6) @(posedge pclk);
      wr(off_in, 32'h02);
      repeat (2) @(posedge pclk);
      chk("channel_locked", {29'h0, analog_channel}, 33'h5);
      wait_busy(1'b0, 100);
      repeat (2) @(posedge pclk);
      chk("channel_next", {29'h0, analog_channel}, 33'h2);
      v = val(4'h5);
      res(v, 1'b0);
      rdx(off_lo, {24'h0, v[7:0]});
      wr(off_a, 32'h90);
      conv(8'hc0, 26, 32);
      rdx(off_a, 32'h90);
      rdx(off_hi, {22'h0, v[9:8]});
      res(v, 1'b0);
      conv(8'hc0, 26, 32);
      res(val(4'h2), 1'b0);
      chk("flag_set", {32'h0, complete_flag}, 33'h1);
      irq_ack <= 1'b1;
      @(posedge pclk);
      irq_ack <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("flag_ack", {32'h0, complete_flag}, 33'h0);
      wr(off_in, 32'h22);
      conv(8'hc0, 26, 32);
      res(val(4'h2), 1'b1);
      for (int n = 1; n < 8; n++)
      begin
         ch = $urandom % 8;
         wr(off_in, ch);
         wr(off_b, n);
         wr(off_a, 32'hb2);
         expect_run(108, 116);
         @(posedge pclk);
         trigger_in[n - 1] <= 1'b1;
         wait_busy(1'b1, 20);
         repeat (20) @(posedge pclk);
         trigger_in[n - 1] <= 1'b0;
         @(posedge pclk);
         trigger_in[n - 1] <= 1'b1;
         wait_busy(1'b0, 400);
         repeat (150) @(posedge pclk);
         trigger_in <= 7'h00;
         res(val(4'(ch)), 1'b0);
      end
      conv(8'he2, 104, 120);
      wr(off_b, 32'h0);
      expect_run(300, 99999);
      s0 = sh_cnt;
      wr(off_a, 32'he0);
      repeat (320) @(posedge pclk);
      chk("free_samples", {32'h0, sh_cnt - s0 >= 10}, 33'h1);
      wr(off_a, 32'hb0);
      repeat (60) @(posedge pclk);
      apb(1'b0, off_a, 32'h0, 33'h40, 33'h40);
      wr(off_a, 32'h80);
      wait_busy(1'b0, 100);
      wr(off_a, 32'h00);
      repeat (2) @(posedge pclk);
      chk("disabled", {32'h0, converter_power}, 33'h0);
      end_sim();
   end
endmodule

/* sim/adcseq_analog_model.sv */
// Behavioural analog front end feeding conversion codes
`timescale 1ns/1ps
module adcseq_analog_model
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       sample_hold,
   input  wire logic [3:0] analog_channel,
   input  wire logic       converter_power,
   input  wire logic [9:0] code_base,
   output logic      [9:0] conv_data
);
   logic [9:0] held_reg;
   // Hold the selected input's code at the sample instant
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         held_reg <= 10'h000;
      else if (sample_hold)
         held_reg <= code_base + {6'h00, analog_channel};
   end
   // Unpowered front end shows the inverted held code
   assign conv_data = converter_power ? held_reg : ~held_reg;
endmodule
